// *** rtl/hcis_top.sv ***
// host channel transaction result and interrupt status, classic wishbone slave
// assumes a serial engine driving the txn_* flags synchronous to clk
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/10ps
`include "hcis_consts.svh"
module hcis_top (
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [11:0]                wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic      [31:0]                wb_dat_o,
    output logic                            wb_ack_o,
    output logic                            irq,
    output logic                            channel_run_bit,
    output hcis_pkg::hcis_result_type       transaction_result_code,
    input  wire logic                       txn_done,
    input  wire logic                       txn_is_in,
    input  wire logic                       txn_stall,
    input  wire logic                       txn_timeout,
    input  wire logic                       txn_crc_err,
    input  wire logic                       txn_stuff_err,
    input  wire logic                       txn_pid_fail,
    input  wire logic                       txn_pid_bad,
    input  wire logic                       txn_toggle_err,
    input  wire logic                       txn_split_err,
    input  wire logic                       txn_split_nyet,
    input  wire logic [`HCIS_PKT_W-1:0]     txn_bytes
);
    import hcis_pkg::*;

    hcis_top_state_type           st_reg;
    hcis_top_state_type           st_next;
    logic                         res_valid;
    hcis_result_type              res_code;
    logic [`HCIS_PKT_W-1:0]       res_bytes;
    logic [`HCIS_TOTAL_W-1:0]     res_wide;
    logic [9:0]                   idx;
    logic                         req;
    logic                         wr;
    logic                         ctrl_wr;
    logic                         fw_start;
    logic                         fw_stop;
    logic                         hw_take;
    logic [`HCIS_ACKCNT_W-1:0]    ack_inc;
    logic [`HCIS_FLAG_W-1:0]      set_vec;
    logic [`HCIS_FLAG_W-1:0]      clr_vec;
    logic [31:0]                  rd_word;

    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_w,
        input logic [31:0] new_w,
        input logic [3:0]  sel
    );
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = new_w[8*b +: 8];
            end
        end
        return res;
    endfunction

    hcis_classify u_classify (
        .clk              (clk),
        .srst             (srst),
        .txn_done         (txn_done),
        .txn_is_in        (txn_is_in),
        .txn_stall        (txn_stall),
        .txn_timeout      (txn_timeout),
        .txn_crc_err      (txn_crc_err),
        .txn_stuff_err    (txn_stuff_err),
        .txn_pid_fail     (txn_pid_fail),
        .txn_pid_bad      (txn_pid_bad),
        .txn_toggle_err   (txn_toggle_err),
        .txn_split_err    (txn_split_err),
        .txn_split_nyet   (txn_split_nyet),
        .txn_bytes        (txn_bytes),
        .max_packet_bytes (st_reg.max_pkt),
        .bytes_left       (st_reg.left),
        .res_valid        (res_valid),
        .res_code         (res_code),
        .res_bytes        (res_bytes)
    );

    assign res_wide = `HCIS_TOTAL_W'(res_bytes);
    assign idx      = wb_adr_i[11:2];
    // one request per ack, no request is taken in the cycle that ack is high
    assign req      = wb_cyc_i && wb_stb_i && !st_reg.ack;
    assign wr       = req && wb_we_i;
    assign ctrl_wr  = wr && (idx == `HCIS_IDX_CTRL) && wb_sel_i[0];
    assign fw_start = ctrl_wr && !st_reg.run && wb_dat_i[`HCIS_CTRL_RUN];
    assign fw_stop  = ctrl_wr && st_reg.run && !wb_dat_i[`HCIS_CTRL_RUN];
    // results only count while the channel runs
    assign hw_take  = res_valid && st_reg.run;
    assign ack_inc  = st_reg.ack_seen + `HCIS_ACKCNT_W'(1);

    // read mux
    always_comb begin
        rd_word = `HCIS_WORD_RST;
        if (idx == `HCIS_IDX_CTRL) begin
            rd_word[`HCIS_CTRL_ACK_HI:`HCIS_CTRL_ACK_LO] = st_reg.ack_cfg;
            rd_word[`HCIS_CTRL_RUN] = st_reg.run;
        end else if (idx == `HCIS_IDX_MASK) begin
            rd_word[`HCIS_FLG_HI:`HCIS_FLG_LO] = st_reg.mask;
        end else if (idx == `HCIS_IDX_RESULT) begin
            rd_word[2:0] = st_reg.code;
        end else if (idx == `HCIS_IDX_MAXPKT) begin
            rd_word[`HCIS_PKT_W-1:0] = st_reg.max_pkt;
        end else if (idx == `HCIS_IDX_TOTAL) begin
            rd_word[`HCIS_TOTAL_W-1:0] = st_reg.total;
        end else if (idx == `HCIS_IDX_LEFT) begin
            rd_word[`HCIS_TOTAL_W-1:0] = st_reg.left;
        // flags in bits 7..4, low nibble reads zero
        end else if (idx == `HCIS_IDX_STATUS) begin
            rd_word[`HCIS_FLG_HI:`HCIS_FLG_LO] = st_reg.flags;
        end
    end

    always_comb begin
        logic [31:0] m;
        m       = `HCIS_WORD_RST;
        st_next = st_reg;
        set_vec = `HCIS_FLAG_RST;
        clr_vec = `HCIS_FLAG_RST;

        // bus answer one cycle after the request is taken
        st_next.ack = req;
        if (req && !wb_we_i) begin
            st_next.dat = rd_word;
        end

        // result handling
        if (hw_take) begin
            st_next.code = res_code;
            case (res_code)
                res_none: begin
                    st_next.retry_run = 2'h0;
                    st_next.left      = st_reg.left - res_wide;
                    if (st_reg.ack_cfg != '0 && ack_inc == st_reg.ack_cfg) begin
                        set_vec[`HCIS_FLG_ACK] = 1'b1;
                        st_next.ack_seen       = '0;
                    end else begin
                        st_next.ack_seen = ack_inc;
                    end
                    if (res_wide == st_reg.left) begin
                        set_vec[`HCIS_FLG_IRP] = 1'b1;
                        st_next.run            = 1'b0;
                    end
                end
                res_stall, overrun_result, underrun_result: begin
                    set_vec[`HCIS_FLG_CC] = 1'b1;
                    st_next.run           = 1'b0;
                    st_next.retry_run     = 2'h0;
                end
                retry_fail_result: begin
                    set_vec[`HCIS_FLG_ERR] = 1'b1;
                    if (st_reg.retry_run == `HCIS_RETRY_LIMIT) begin
                        set_vec[`HCIS_FLG_CC] = 1'b1;
                        st_next.run           = 1'b0;
                        st_next.retry_run     = 2'h0;
                    end else begin
                        st_next.retry_run = st_reg.retry_run + 2'h1;
                    end
                end
                default: begin
                    st_next.code = st_reg.code;
                end
            endcase
        end

        // firmware register writes
        if (ctrl_wr) begin
            st_next.ack_cfg = wb_dat_i[`HCIS_CTRL_ACK_HI:`HCIS_CTRL_ACK_LO];
        end
        if (fw_start) begin
            st_next.run       = 1'b1;
            st_next.left      = st_reg.total;
            st_next.ack_seen  = '0;
            st_next.retry_run = 2'h0;
        end
        if (fw_stop) begin
            st_next.run           = 1'b0;
            set_vec[`HCIS_FLG_CC] = 1'b1;
        end
        if (wr && idx == `HCIS_IDX_MASK && wb_sel_i[0]) begin
            st_next.mask = wb_dat_i[`HCIS_FLG_HI:`HCIS_FLG_LO];
        end
        if (wr && idx == `HCIS_IDX_MAXPKT) begin
            m = lane_merge(32'(st_reg.max_pkt), wb_dat_i, wb_sel_i);
            st_next.max_pkt = m[`HCIS_PKT_W-1:0];
        end
        if (wr && idx == `HCIS_IDX_TOTAL) begin
            m = lane_merge(32'(st_reg.total), wb_dat_i, wb_sel_i);
            st_next.total = m[`HCIS_TOTAL_W-1:0];
        end
        if (wr && idx == `HCIS_IDX_STATUS && wb_sel_i[0]) begin
            clr_vec = wb_dat_i[`HCIS_FLG_HI:`HCIS_FLG_LO];
        end

        st_next.flags = (st_reg.flags & ~clr_vec) | set_vec;
        st_next.irq   = |(st_next.flags & st_next.mask);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg.run       <= 1'b0;
            st_reg.ack_cfg   <= '0;
            st_reg.mask      <= `HCIS_FLAG_RST;
            st_reg.flags     <= `HCIS_FLAG_RST;
            st_reg.code      <= res_none;
            st_reg.max_pkt   <= `HCIS_MAXPKT_RST;
            st_reg.total     <= `HCIS_TOTAL_RST;
            st_reg.left      <= `HCIS_TOTAL_RST;
            st_reg.ack_seen  <= '0;
            st_reg.retry_run <= 2'h0;
            st_reg.ack       <= 1'b0;
            st_reg.dat       <= `HCIS_WORD_RST;
            st_reg.irq       <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_dat_o                = st_reg.dat;
    assign wb_ack_o                = st_reg.ack;
    assign irq                     = st_reg.irq;
    assign channel_run_bit         = st_reg.run;
    assign transaction_result_code = st_reg.code;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    AST_STATUS_RESET: assert property (
        $fell(srst) |-> (st_reg.flags == `HCIS_FLAG_RST))
        else $error("status not zero after reset");

    AST_W1C_CLEAR: assert property (
        (clr_vec[`HCIS_FLG_ERR] && !set_vec[`HCIS_FLG_ERR])
        |=> !st_reg.flags[`HCIS_FLG_ERR])
        else $error("write one did not clear the flag");

    AST_SET_WINS: assert property (
        (set_vec != `HCIS_FLAG_RST)
        |=> ((st_reg.flags & $past(set_vec)) == $past(set_vec)))
        else $error("hardware set lost against clear");

    AST_STALL_CC: assert property (
        (txn_done && txn_stall && st_reg.run) ##1 st_reg.run
        |=> (st_reg.flags[`HCIS_FLG_CC] && st_reg.code == res_stall))
        else $error("stall did not set condition changed");

    AST_FW_STOP: assert property (
        (fw_stop && !hw_take)
        |=> (st_reg.flags[`HCIS_FLG_CC] && $stable(st_reg.code) && !st_reg.run))
        else $error("firmware stop mishandled");

    AST_TXN_ERR: assert property (
        (hw_take && res_code == retry_fail_result)
        |=> st_reg.flags[`HCIS_FLG_ERR])
        else $error("error transaction did not set error flag");

    AST_ACK_COUNT: assert property (
        (hw_take && res_code == res_none && st_reg.ack_cfg != '0
         && ack_inc == st_reg.ack_cfg)
        |=> (st_reg.flags[`HCIS_FLG_ACK] && st_reg.ack_seen == '0))
        else $error("acknowledge count reached without flag");

    AST_IRP_DONE: assert property (
        (hw_take && res_code == res_none && res_wide == st_reg.left)
        |=> (st_reg.flags[`HCIS_FLG_IRP] && !st_reg.run))
        else $error("request completion not flagged");

    AST_RETRY3: assert property (
        (hw_take && res_code == retry_fail_result
         && st_reg.retry_run == `HCIS_RETRY_LIMIT)
        |=> (st_reg.flags[`HCIS_FLG_CC] && st_reg.retry_run == 2'h0))
        else $error("third retry did not set condition changed");

    AST_ACK_PULSE: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held for more than one cycle");

    AST_ACK_NEXT: assert property (
        req |=> wb_ack_o)
        else $error("bus request not answered in the next cycle");

    AST_IRQ_LEVEL: assert property (
        irq == |(st_reg.flags & st_reg.mask))
        else $error("interrupt level disagrees with unmasked flags");

    AST_RSVD_ZERO: assert property (
        (req && !wb_we_i && idx == `HCIS_IDX_STATUS)
        |=> (wb_dat_o[`HCIS_FLG_LO-1:0] == '0))
        else $error("reserved status bits read nonzero");

    AST_CODE_HOLD: assert property (
        !hw_take |=> $stable(st_reg.code))
        else $error("result code changed without a counted result");

    AST_HW_STOP: assert property (
        (st_reg.run && !st_next.run && !fw_stop)
        |=> (st_reg.flags[`HCIS_FLG_IRP] || st_reg.flags[`HCIS_FLG_CC]))
        else $error("channel stopped without a cause flag");

    AST_OK_NO_ERR: assert property (
        (hw_take && res_code == res_none && !st_reg.flags[`HCIS_FLG_ERR])
        |=> !st_reg.flags[`HCIS_FLG_ERR])
        else $error("clean transaction set the error flag");

    AST_ACK_OFF: assert property (
        (hw_take && st_reg.ack_cfg == '0 && !st_reg.flags[`HCIS_FLG_ACK])
        |=> !st_reg.flags[`HCIS_FLG_ACK])
        else $error("acknowledge flag set with count disabled");
endmodule

// *** rtl/hcis_consts.svh ***
// constants for the host channel result and interrupt status block
// assumes inclusion by bare name from the package and the top module
`ifndef HCIS_CONSTS_SVH
`define HCIS_CONSTS_SVH

// register word indices, byte address is four times the index
`define HCIS_IDX_CTRL     10'h000
`define HCIS_IDX_MASK     10'h001
`define HCIS_IDX_RESULT   10'h002
`define HCIS_IDX_MAXPKT   10'h003
`define HCIS_IDX_TOTAL    10'h004
`define HCIS_IDX_LEFT     10'h005
`define HCIS_IDX_STATUS   10'h0EA

// field widths
`define HCIS_PKT_W        11
`define HCIS_TOTAL_W      16
`define HCIS_ACKCNT_W     4
`define HCIS_FLAG_W       4

// control register fields
`define HCIS_CTRL_RUN     0
`define HCIS_CTRL_ACK_LO  4
`define HCIS_CTRL_ACK_HI  7

// cause flags inside the 4-bit flag vector (status bits 7..4)
`define HCIS_FLG_IRP      3
`define HCIS_FLG_ACK      2
`define HCIS_FLG_ERR      1
`define HCIS_FLG_CC       0
`define HCIS_FLG_LO       4
`define HCIS_FLG_HI       7

// transaction result codes
`define HCIS_RC_OK        3'h0
`define HCIS_RC_STALL     3'h1
`define HCIS_RC_OVER      3'h2
`define HCIS_RC_UNDER     3'h3
`define HCIS_RC_RETRY     3'h4

// consecutive limits, value before the third event
`define HCIS_RETRY_LIMIT  2'h2
`define HCIS_NYET_LIMIT   2'h2

// reset values
`define HCIS_FLAG_RST     4'h0
`define HCIS_MAXPKT_RST   11'h040
`define HCIS_TOTAL_RST    16'h0000
`define HCIS_WORD_RST     32'h0000_0000

`endif

// *** rtl/hcis_pkg.sv ***
// types shared by the host channel result and interrupt status block
// assumes the constants header is reachable by bare name
package hcis_pkg;
`include "hcis_consts.svh"

    typedef enum logic [2:0] {
        res_none          = `HCIS_RC_OK,
        res_stall         = `HCIS_RC_STALL,
        overrun_result    = `HCIS_RC_OVER,
        underrun_result   = `HCIS_RC_UNDER,
        retry_fail_result = `HCIS_RC_RETRY
    } hcis_result_type;

    typedef struct packed {
        logic                       valid;
        hcis_result_type            code;
        logic [`HCIS_PKT_W-1:0]     bytes;
        logic [1:0]                 nyet_cnt;
    } hcis_cls_state_type;

    typedef struct packed {
        logic                       run;
        logic [`HCIS_ACKCNT_W-1:0]  ack_cfg;
        logic [`HCIS_FLAG_W-1:0]    mask;
        logic [`HCIS_FLAG_W-1:0]    flags;
        hcis_result_type            code;
        logic [`HCIS_PKT_W-1:0]     max_pkt;
        logic [`HCIS_TOTAL_W-1:0]   total;
        logic [`HCIS_TOTAL_W-1:0]   left;
        logic [`HCIS_ACKCNT_W-1:0]  ack_seen;
        logic [1:0]                 retry_run;
        logic                       ack;
        logic [31:0]                dat;
        logic                       irq;
    } hcis_top_state_type;
endpackage

// *** rtl/hcis_classify.sv ***
// transaction outcome classifier: one registered result per finished transaction, none for the first two consecutive nyets
// assumes the serial engine flags are valid in the cycle of txn_done
`timescale 1ns/10ps
`include "hcis_consts.svh"
module hcis_classify (
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic                       txn_done,
    input  wire logic                       txn_is_in,
    input  wire logic                       txn_stall,
    input  wire logic                       txn_timeout,
    input  wire logic                       txn_crc_err,
    input  wire logic                       txn_stuff_err,
    input  wire logic                       txn_pid_fail,
    input  wire logic                       txn_pid_bad,
    input  wire logic                       txn_toggle_err,
    input  wire logic                       txn_split_err,
    input  wire logic                       txn_split_nyet,
    input  wire logic [`HCIS_PKT_W-1:0]     txn_bytes,
    input  wire logic [`HCIS_PKT_W-1:0]     max_packet_bytes,
    input  wire logic [`HCIS_TOTAL_W-1:0]   bytes_left,
    output logic                            res_valid,
    output hcis_pkg::hcis_result_type       res_code,
    output logic [`HCIS_PKT_W-1:0]          res_bytes
);
    import hcis_pkg::*;

    hcis_cls_state_type           st_reg;
    hcis_cls_state_type           st_next;
    logic [`HCIS_TOTAL_W-1:0]     rx_wide;
    logic                         over_pkt;
    logic                         over_tot;
    logic                         under;
    logic                         hard;
    logic                         nyet3;

    assign rx_wide  = `HCIS_TOTAL_W'(txn_bytes);
    assign over_pkt = txn_is_in && (txn_bytes > max_packet_bytes);
    assign over_tot = txn_is_in && (rx_wide > bytes_left);
    assign under    = txn_is_in && (txn_bytes < max_packet_bytes) && (rx_wide < bytes_left);
    assign hard     = txn_crc_err || txn_stuff_err || txn_timeout || txn_pid_fail
                      || txn_pid_bad || txn_split_err;
    assign nyet3    = txn_split_nyet && (st_reg.nyet_cnt == `HCIS_NYET_LIMIT);

    always_comb begin
        st_next       = st_reg;
        st_next.valid = 1'b0;
        if (txn_done) begin
            if (txn_split_nyet && !nyet3 && !hard && !txn_stall) begin
                st_next.nyet_cnt = st_reg.nyet_cnt + 2'h1;
            end else begin
                st_next.nyet_cnt = 2'h0;
                st_next.valid    = 1'b1;
                st_next.bytes    = txn_bytes;
                if (txn_stall) begin
                    st_next.code = res_stall;
                // crc or stuffing beats overrun and underrun
                // in-size toggle mismatch is not an overrun
                end else if (hard || nyet3 || (txn_toggle_err && !over_pkt)) begin
                    st_next.code = retry_fail_result;
                end else if (over_pkt || over_tot) begin
                    st_next.code = overrun_result;
                end else if (under) begin
                    st_next.code = underrun_result;
                end else begin
                    st_next.code = res_none;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg.valid    <= 1'b0;
            st_reg.code     <= res_none;
            st_reg.bytes    <= '0;
            st_reg.nyet_cnt <= 2'h0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign res_valid = st_reg.valid;
    assign res_code  = st_reg.code;
    assign res_bytes = st_reg.bytes;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    AST_CODE_LEGAL: assert property (
        res_valid |-> (res_code inside {res_none, res_stall, overrun_result,
                                        underrun_result, retry_fail_result}))
        else $error("reserved result code produced");

    AST_CRC_RETRY: assert property (
        (txn_done && (txn_crc_err || txn_stuff_err) && !txn_stall)
        |=> (res_valid && res_code == retry_fail_result))
        else $error("crc or stuffing error not reported as retry");

    AST_OVERRUN: assert property (
        (txn_done && !txn_stall && !hard && !txn_split_nyet && txn_is_in
         && (txn_bytes > max_packet_bytes))
        |=> (res_valid && res_code == overrun_result))
        else $error("oversize packet not reported as overrun");

    AST_TOGGLE: assert property (
        (txn_done && txn_toggle_err && !txn_stall && !txn_split_nyet
         && (txn_bytes <= max_packet_bytes))
        |=> (res_valid && res_code == retry_fail_result))
        else $error("in-size toggle mismatch not reported as retry");

    AST_UNDERRUN: assert property (
        (txn_done && !txn_stall && !hard && !txn_split_nyet && !txn_toggle_err
         && under)
        |=> (res_valid && res_code == underrun_result))
        else $error("short packet not reported as underrun");

    AST_TIMEOUT: assert property (
        (txn_done && txn_timeout && !txn_stall)
        |=> (res_valid && res_code == retry_fail_result))
        else $error("timeout not reported as retry");

    AST_SPLIT_ERR: assert property (
        (txn_done && txn_split_err && !txn_stall)
        |=> (res_valid && res_code == retry_fail_result))
        else $error("split err handshake not reported as retry");
endmodule

// *** sim/hcis_engine_model.sv ***
// serial engine stand-in: one txn_done pulse per request from the bench
// assumes go, fl and by change just after a rising edge of clk
`timescale 1ns/10ps
`include "hcis_consts.svh"
module hcis_engine_model (
    input  wire logic                   clk,
    input  wire logic                   go,
    input  wire logic [9:0]             fl,
    input  wire logic [`HCIS_PKT_W-1:0] by,
    output logic                        txn_done,
    output logic [9:0]                  txn_flags,
    output logic [`HCIS_PKT_W-1:0]      txn_bytes
);
    // between pulses the qualified lines carry a changing pattern
    initial begin
        txn_done = 1'b0;
        txn_flags = 10'h000;
        txn_bytes = 11'h000;
    end
    always @(posedge clk) begin
        txn_done <= go;
        txn_flags <= go ? fl : ~txn_flags;
        txn_bytes <= go ? by : ~txn_bytes;
    end
endmodule

// *** sim/host_channel_irq_status_bench.sv ***
// self-checking bench: bus reads queue expectations, a monitor compares on ack
// assumes the design answers every bus request with a one-cycle ack
`timescale 1ns/10ps
module host_channel_irq_status_bench;
    import hcis_pkg::*;
    logic clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, go = 0, ack, irq, done, run;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0000_0000, rdat, q[$];
    logic [9:0] fl = 10'h000, tf;
    logic [10:0] by = 11'h000, tb;
    int n_fail = 0, n_checks = 0, i, k;
    hcis_result_type code;
    // flags, bytes (0 is random), count, code, status
    localparam logic [33:0] tab [13] = '{
        {10'h100, 11'h000, 2'd1, 3'h1, 8'h10}, {10'h200, 11'h050, 2'd1, 3'h2, 8'h10},
        {10'h240, 11'h050, 2'd1, 3'h4, 8'h20}, {10'h200, 11'h00A, 2'd1, 3'h3, 8'h10},
        {10'h220, 11'h00A, 2'd1, 3'h4, 8'h20}, {10'h080, 11'h000, 2'd1, 3'h4, 8'h20},
        {10'h010, 11'h000, 2'd1, 3'h4, 8'h20}, {10'h008, 11'h000, 2'd1, 3'h4, 8'h20},
        {10'h204, 11'h040, 2'd1, 3'h4, 8'h20}, {10'h200, 11'h040, 2'd2, 3'h0, 8'hC0},
        {10'h080, 11'h000, 2'd3, 3'h4, 8'h30}, {10'h002, 11'h000, 2'd1, 3'h4, 8'h20},
        {10'h001, 11'h000, 2'd3, 3'h4, 8'h20}};
    hcis_engine_model eng (.clk(clk), .go(go), .fl(fl), .by(by), .txn_done(done),
        .txn_flags(tf), .txn_bytes(tb));
    hcis_top dut (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .irq(irq), .channel_run_bit(run), .transaction_result_code(code), .txn_done(done),
        .txn_is_in(tf[9]), .txn_stall(tf[8]), .txn_timeout(tf[7]), .txn_crc_err(tf[6]),
        .txn_stuff_err(tf[5]), .txn_pid_fail(tf[4]), .txn_pid_bad(tf[3]),
        .txn_toggle_err(tf[2]), .txn_split_err(tf[1]), .txn_split_nyet(tf[0]),
        .txn_bytes(tb));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
        if (!w) q.push_back(d);
        @(posedge clk);
        while (!ack) @(posedge clk);
        cyc <= 0; stb <= 0;
    endtask
    // read results are compared in the ack cycle
    always @(posedge clk) begin
        if (ack && !we) chk("rd", rdat, q.pop_front());
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic prep(input logic [31:0] m);
        wb(1, 12'h000, 32'h0000_0000); wb(1, 12'h3A8, 32'h0000_00F0);
        wb(1, 12'h004, m); wb(1, 12'h010, 32'h0000_0080); wb(1, 12'h000, 32'h0000_0021);
    endtask
    initial begin
        void'($urandom(32'h326703d1));
        repeat (20) @(posedge clk);
        srst <= 0;
        // reset value and an unmapped place
        wb(0, 12'h3A8, 32'h0000_0000); wb(0, 12'h100, 32'h0000_0000);
        for (i = 0; i < 13; i++) begin
            prep(i == 0 ? 32'h0000_0000 : 32'h0000_00F0);
            for (k = 0; k < tab[i][12:11]; k++) begin
                @(posedge clk);
                go <= 1; fl <= tab[i][33:24];
                by <= tab[i][23:13] != 0 ? tab[i][23:13] : 11'($urandom % 2048);
                @(posedge clk);
                go <= 0;
            end
            repeat (3) @(posedge clk);
            wb(0, 12'h008, {29'h0, tab[i][10:8]}); wb(0, 12'h3A8, {24'h0, tab[i][7:0]});
            chk("irq", irq, i != 0 && tab[i][7:0] != 0);
            chk("code", code, tab[i][10:8]);
            chk("run", run, !(tab[i][7] || tab[i][4]));
            wb(1, 12'h3A8, 32'h0000_00F0); wb(0, 12'h3A8, 32'h0000_0000);
            chk("irq", irq, 0);
            $display("test %0d done", i);
        end
        // a timeout result lands in the cycle that a write-one clear is taken
        @(posedge clk);
        go <= 1; fl <= 10'h080;
        @(posedge clk);
        go <= 0;
        wb(1, 12'h3A8, 32'h0000_00F0); wb(0, 12'h3A8, 32'h0000_0020);
        $display("test set against clear done");
        // firmware stop keeps the last code
        wb(1, 12'h000, 32'h0000_0000); wb(0, 12'h3A8, 32'h0000_0030);
        wb(0, 12'h008, 32'h0000_0004);
        chk("run", run, 0);
        $display("test firmware stop done");
        repeat (3) @(posedge clk);
        finish_test();
    end
    initial begin
        #200000;
        n_fail++;
        finish_test();
    end
endmodule
